// file: phy_mgmt_defs.svh
`ifndef PHY_MGMT_DEFS_SVH
`define PHY_MGMT_DEFS_SVH

// clause 22 register addresses (5-bit)
`define REG_MS_STATUS_ADDR 5'h0A
`define REG_EXT_ABILITY_ADDR 5'h0F
`define REG_IND_PTR_ADDR 5'h10
`define REG_IND_DATA_ADDR 5'h11
`define REG_XOVER_CTRL_ADDR 5'h12

// reset values
`define EXT_ABILITY_RESET 16'h0000
`define IND_PTR_RESET 16'h0000
`define XOVER_CTRL_RESET 16'h0002
`define XOVER_CTRL_RSVD_RESET 2'h2

// crossover control field positions
`define XOVER_AUTO_BIT 10
`define XOVER_MAN_BIT 9
`define XOVER_DIAG_BIT 2

// writable mask of crossover control: bits 10, 9, 2, 1, 0
`define XOVER_CTRL_WMASK 16'h0607

// this device's own mdio port and mmd addresses
`define PHY_PORT_ADDR 5'h00
`define EXT_MAP_MMD 5'h1E

// extended register map: words held locally
`define EXT_MAP_WORDS 16
`define EXT_MAP_IDX_W 4

// mdio frame codes
`define ST_C22 2'h1
`define ST_C45 2'h0
`define OP_C22_WR 2'h1
`define OP_C22_RD 2'h2
`define OP_C45_ADDR 2'h0
`define OP_C45_WR 2'h1
`define OP_C45_RDINC 2'h2
`define OP_C45_RD 2'h3

`endif

// file: phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  // mdio serial engine states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_HEAD = 6'h02,
    S_TA = 6'h04,
    S_RDATA = 6'h08,
    S_WDATA = 6'h10,
    S_WAIT = 6'h20
  } mdio_state_t;

  // register access request from the link domain
  typedef struct packed {
    logic is_c45;
    logic is_write;
    logic [1:0] op;
    logic [4:0] dev;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage : phy_mgmt_pkg

// file: mdio_link.sv
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"

// mdio serial engine on the mdc clock; hands each frame addressed to its own port to the system
// domain with a toggle and takes the read word one mdc period later without waiting for the ack toggle.
module mdio_link (
  input wire logic i_mdc,
  input wire logic i_rst_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  output phy_mgmt_pkg::mgmt_req_t o_req,
  output logic o_req_tgl,
  input wire logic i_ack_tgl,
  input wire logic [15:0] i_rdata
);

  typedef struct packed {
    phy_mgmt_pkg::mdio_state_t st;
    logic [5:0] ones;
    logic [5:0] cnt;
    logic [13:0] head;
    logic [15:0] sh;
    phy_mgmt_pkg::mgmt_req_t req;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic mdio_o;
    logic mdio_oe;
  } link_state_t;

  link_state_t r_reg;
  link_state_t r_next;

  // frame decoder; the reply word is taken one mdc period after the request
  // toggles, by which time the system side has long settled it
  always_comb begin
    r_next = r_reg;
    r_next.ack_s1 = i_ack_tgl;
    r_next.ack_s2 = r_reg.ack_s1;
    case (r_reg.st)
      phy_mgmt_pkg::S_IDLE: begin
        r_next.mdio_oe = 1'b0;
        r_next.ones = (i_mdio && r_reg.ones != 6'h3F) ? r_reg.ones + 6'h01 : (i_mdio ? r_reg.ones : 6'h00);
        if (!i_mdio && r_reg.ones >= 6'h1F) begin // preamble then first start bit
          r_next.st = phy_mgmt_pkg::S_HEAD;
          r_next.cnt = 6'h00;
          r_next.head = 14'h0000;
          r_next.ones = 6'h00;
        end
      end
      phy_mgmt_pkg::S_HEAD: begin
        // second start bit, op, port, reg/dev: 13 more bits
        r_next.head = {r_reg.head[12:0], i_mdio};
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == 6'h0C) begin
          r_next.req.is_c45 = (r_reg.head[11] == 1'b0);
          r_next.req.op = r_reg.head[10:9];
          r_next.req.dev = {r_reg.head[3:0], i_mdio};
          r_next.req.reg_addr = {r_reg.head[3:0], i_mdio};
          r_next.req.is_write = (r_reg.head[10:9] == `OP_C22_WR) ||
            (r_reg.head[11] == 1'b0 && r_reg.head[10] == 1'b0);
          if (r_reg.head[8:4] != `PHY_PORT_ADDR) begin
            r_next.st = phy_mgmt_pkg::S_IDLE; // frame for another port
          end else begin
            r_next.st = phy_mgmt_pkg::S_TA;
            r_next.cnt = 6'h00;
          end
        end
      end
      phy_mgmt_pkg::S_TA: begin
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.req.is_write) begin
          if (r_reg.cnt == 6'h01) begin
            r_next.st = phy_mgmt_pkg::S_WDATA;
            r_next.cnt = 6'h00;
          end
        end else if (r_reg.cnt == 6'h00) begin
          // read: issue request now, drive zero in second turnaround bit
          r_next.req.wdata = 16'h0000;
          r_next.req_tgl = ~r_reg.req_tgl;
          r_next.ack_seen = r_reg.ack_s2;
          r_next.mdio_oe = 1'b1;
          r_next.mdio_o = 1'b0;
        end else begin
          r_next.st = phy_mgmt_pkg::S_RDATA;
          r_next.cnt = 6'h00;
          r_next.sh = i_rdata;
          r_next.mdio_o = i_rdata[15];
        end
      end
      phy_mgmt_pkg::S_RDATA: begin
        // limitation: reply assumed back within one mdc cycle (mdc << sys clock)
        r_next.cnt = r_reg.cnt + 6'h01;
        r_next.sh = {r_reg.sh[14:0], 1'b0};
        r_next.mdio_o = r_reg.sh[14];
        if (r_reg.cnt == 6'h0F) begin
          r_next.st = phy_mgmt_pkg::S_IDLE;
          r_next.mdio_oe = 1'b0;
        end
      end
      phy_mgmt_pkg::S_WDATA: begin
        r_next.cnt = r_reg.cnt + 6'h01;
        r_next.req.wdata = {r_reg.req.wdata[14:0], i_mdio};
        if (r_reg.cnt == 6'h0F) begin
          r_next.req_tgl = ~r_reg.req_tgl;
          r_next.st = phy_mgmt_pkg::S_IDLE;
        end
      end
      default: begin
        r_next.st = phy_mgmt_pkg::S_IDLE;
        r_next.mdio_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mdc) begin
    if (i_rst_mdc) begin
      r_reg <= '0;
      r_reg.st <= phy_mgmt_pkg::S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_mdio = r_reg.mdio_o;
  assign o_mdio_oe = r_reg.mdio_oe;
  assign o_req = r_reg.req;
  assign o_req_tgl = r_reg.req_tgl;

endmodule : mdio_link

// file: phy_mgmt_indirect_regs.sv
`timescale 1ns/1ps
`include "phy_mgmt_defs.svh"

// Operation
// - An eight-bit idle error tally accumulates and clears itself when read.
// - The extended ability status register reads zero in all sixteen bits.
// - Data window reads return, and writes update, the extended register the pointer selects.
// - Pointer, data window and indirect registers are reachable with clause 22 frames.
// - Clause 45 frames reach the extended register map directly.
// - Auto crossover enable resolves MDI/MDIX automatically, preferring the manual select.
// - The auto crossover enable resets to the value of a strap pin.
// - With auto off, manual select one gives crossed MDIX and zero gives straight MDI.
// - The diagnostics clock gate bit enables the diagnostics clock when one.
// - The crossover control register resets to 0x0002, low reserved bits at binary ten.
module phy_mgmt_indirect_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic i_strap_auto_xover,
  input wire logic i_idle_error,
  input wire logic i_rx_idle,
  input wire logic i_partner_sees_mdix,
  output logic o_mdix_active,
  output logic o_diagnostics_clock_gate,
  output logic [15:0] o_idle_err_tally_view
);

  // mdc domain reset: the system reset passed through two mdc flops
  logic [1:0] mdc_rst_sync;
  always_ff @(posedge i_mdc) begin
    mdc_rst_sync <= {mdc_rst_sync[0], i_rst};
  end

  phy_mgmt_pkg::mgmt_req_t link_req;
  logic link_req_tgl;

  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0] err_s;
    logic [1:0] idle_s;
    logic [1:0] partner_s;
    logic err_d;
    logic [2:0] req_s;
    logic ack_tgl;
    logic [15:0] rdata;
    logic [7:0] idle_tally;
    logic [15:0] ind_ptr;
    logic [15:0] c45_addr;
    logic [15:0] xover_ctrl;
    logic strap_armed;
    logic mdix_active;
    logic [`EXT_MAP_WORDS-1:0][15:0] ext_map; // packed so the whole bank stays one packed word
  } regs_state_t;

  regs_state_t r_reg;
  regs_state_t r_next;

  // serial engine on the link clock
  mdio_link u_link (
    .i_mdc(i_mdc),
    .i_rst_mdc(mdc_rst_sync[1]),
    .i_mdio(i_mdio),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe),
    .o_req(link_req),
    .o_req_tgl(link_req_tgl),
    .i_ack_tgl(r_reg.ack_tgl),
    .i_rdata(r_reg.rdata)
  );

  // extended map index: low bits of the 16-bit address, the rest aliases
  function automatic logic [`EXT_MAP_IDX_W-1:0] ext_idx(input logic [15:0] addr);
    ext_idx = addr[`EXT_MAP_IDX_W-1:0];
  endfunction : ext_idx

  // clause 22 read decode
  function automatic logic [15:0] c22_read(input regs_state_t s, input logic [4:0] a);
    case (a)
      `REG_MS_STATUS_ADDR: c22_read = {8'h00, s.idle_tally};
      `REG_EXT_ABILITY_ADDR: c22_read = `EXT_ABILITY_RESET;
      `REG_IND_PTR_ADDR: c22_read = s.ind_ptr;
      `REG_IND_DATA_ADDR: c22_read = s.ext_map[ext_idx(s.ind_ptr)];
      `REG_XOVER_CTRL_ADDR: c22_read = s.xover_ctrl;
      default: c22_read = 16'h0000;
    endcase
  endfunction : c22_read

  logic req_evt;
  assign req_evt = r_reg.req_s[2] ^ r_reg.req_s[1];

  // register bank; a request word is read only after its toggle crossed,
  // so the bundle has been stable for at least two system edges
  always_comb begin
    r_next = r_reg;
    r_next.strap_s = {r_reg.strap_s[0], i_strap_auto_xover};
    r_next.err_s = {r_reg.err_s[0], i_idle_error};
    r_next.idle_s = {r_reg.idle_s[0], i_rx_idle};
    r_next.partner_s = {r_reg.partner_s[0], i_partner_sees_mdix};
    r_next.req_s = {r_reg.req_s[1:0], link_req_tgl};
    r_next.err_d = r_reg.err_s[1];

    // catch strap once after reset release
    if (r_reg.strap_armed) begin
      r_next.xover_ctrl[`XOVER_AUTO_BIT] = r_reg.strap_s[1];
      r_next.strap_armed = 1'b0;
    end

    // idle errors counted on rising edge while idles are received, saturating
    if (r_reg.err_s[1] && !r_reg.err_d && r_reg.idle_s[1] && r_reg.idle_tally != 8'hFF) begin
      r_next.idle_tally = r_reg.idle_tally + 8'h01;
    end

    if (req_evt) begin
      r_next.ack_tgl = ~r_reg.ack_tgl;
      if (!link_req.is_c45) begin
        // clause 22 access
        r_next.rdata = c22_read(r_reg, link_req.reg_addr);
        if (!link_req.is_write && link_req.reg_addr == `REG_MS_STATUS_ADDR) begin
          // clear on read; an error arriving in the same cycle is kept
          r_next.idle_tally = (r_reg.err_s[1] && !r_reg.err_d && r_reg.idle_s[1]) ? 8'h01 : 8'h00;
        end
        if (link_req.is_write) begin
          case (link_req.reg_addr)
            `REG_IND_PTR_ADDR: r_next.ind_ptr = link_req.wdata;
            `REG_IND_DATA_ADDR: r_next.ext_map[ext_idx(r_reg.ind_ptr)] = link_req.wdata;
            `REG_XOVER_CTRL_ADDR: begin
              r_next.xover_ctrl = (link_req.wdata & `XOVER_CTRL_WMASK);
              r_next.strap_armed = 1'b0;
            end
            default: r_next.rdata = r_next.rdata;
          endcase
        end
        // pointer itself is left untouched by data accesses
      end else if (link_req.dev == `EXT_MAP_MMD) begin
        // clause 45 access straight to the extended map
        case (link_req.op)
          `OP_C45_ADDR: r_next.c45_addr = link_req.wdata;
          `OP_C45_WR: r_next.ext_map[ext_idx(r_reg.c45_addr)] = link_req.wdata;
          `OP_C45_RDINC: begin
            r_next.rdata = r_reg.ext_map[ext_idx(r_reg.c45_addr)];
            r_next.c45_addr = r_reg.c45_addr + 16'h0001;
          end
          default: r_next.rdata = r_reg.ext_map[ext_idx(r_reg.c45_addr)];
        endcase
      end else begin
        r_next.rdata = 16'h0000; // unimplemented mmd reads zero
      end
    end

    // crossover resolution
    if (r_reg.xover_ctrl[`XOVER_AUTO_BIT]) begin
      // auto: follow the preference unless the partner already took that role
      r_next.mdix_active = r_reg.partner_s[1] ? ~r_reg.xover_ctrl[`XOVER_MAN_BIT] :
        r_reg.xover_ctrl[`XOVER_MAN_BIT];
    end else begin
      r_next.mdix_active = r_reg.xover_ctrl[`XOVER_MAN_BIT];
    end
  end

  // one register process for the whole bank
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.strap_s <= r_next.strap_s; // strap keeps settling in reset so the first capture sees the pin
      r_reg.xover_ctrl <= `XOVER_CTRL_RESET;
      r_reg.ind_ptr <= `IND_PTR_RESET;
      r_reg.strap_armed <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_mdix_active = r_reg.mdix_active;
  assign o_diagnostics_clock_gate = r_reg.xover_ctrl[`XOVER_DIAG_BIT];
  assign o_idle_err_tally_view = {8'h00, r_reg.idle_tally};

endmodule : phy_mgmt_indirect_regs

// file: phy_mgmt_indirect_regs_asserts.sv
`timescale 1ns/1ps
// port-level checks of the management register block
module phy_mgmt_indirect_regs_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_mdc,
  input wire logic i_rx_idle,
  input wire logic o_mdio,
  input wire logic o_mdio_oe,
  input wire logic o_mdix_active,
  input wire logic o_diagnostics_clock_gate,
  input wire logic [15:0] o_idle_err_tally_view
);
  logic [5:0] oe_run_reg;
  wire logic [15:0] tv = o_idle_err_tally_view;

  // length of each read drive in mdc edges; a wrong length corrupts the frame
  always_ff @(posedge i_mdc) begin
    oe_run_reg <= (o_mdio_oe && !i_rst) ? oe_run_reg + 6'h01 : 6'h00;
  end

  AST_RST_OUTS: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(i_rst) |-> tv == 16'h0000 && !o_diagnostics_clock_gate && !o_mdix_active) else $error("outputs not reset");
  AST_TALLY_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    tv[15:8] == 8'h00) else $error("tally upper byte set");
  AST_TALLY_STEP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (tv > $past(tv)) |-> tv == $past(tv) + 16'h0001) else $error("tally jumped");
  AST_TALLY_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (tv < $past(tv)) |-> tv <= 16'h0001) else $error("tally dropped to nonzero");
  AST_TALLY_SAT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ($past(tv) == 16'h00FF) |-> tv inside {16'h00FF, 16'h0000, 16'h0001}) else $error("tally wrapped");
  AST_IDLE_ONLY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_rx_idle) [*6] |=> tv <= $past(tv)) else $error("tally counted outside idle");
  AST_TA_LOW: assert property (@(posedge i_mdc) disable iff (i_rst)
    $rose(o_mdio_oe) |-> !o_mdio) else $error("turnaround bit not low");
  AST_OE_LEN: assert property (@(posedge i_mdc) disable iff (i_rst)
    $fell(o_mdio_oe) |-> oe_run_reg == 6'h11) else $error("read drive length wrong");
  AST_OE_GAP: assert property (@(posedge i_mdc) disable iff (i_rst)
    $fell(o_mdio_oe) |-> !o_mdio_oe [*8]) else $error("drive resumed too soon");
endmodule : phy_mgmt_indirect_regs_asserts

bind phy_mgmt_indirect_regs phy_mgmt_indirect_regs_asserts chk_u (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_mdc(i_mdc), .i_rx_idle(i_rx_idle),
  .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_mdix_active(o_mdix_active),
  .o_diagnostics_clock_gate(o_diagnostics_clock_gate), .o_idle_err_tally_view(o_idle_err_tally_view));

// file: mdio_station.sv
`timescale 1ns/1ps
// station manager model; mdc only runs inside frames and reset
module mdio_station (
  output logic o_mdc,
  output logic o_drv,
  output logic o_drv_oe,
  input wire logic i_wire
);
  initial begin
    o_mdc = 1'b0;
    o_drv = 1'b1;
    o_drv_oe = 1'b0;
  end

  // one 48 ns bit; change after the falling edge, sample just before the rising
  // edge, since the device launches each read bit on the rising edge before
  task automatic slot(input logic b, input logic oe, output logic s);
    o_drv = b;
    o_drv_oe = oe;
    #22 s = i_wire;
    #2 o_mdc = 1'b1;
    #24 o_mdc = 1'b0;
  endtask : slot

  task automatic idle(input int n);
    logic s;
    repeat (n) slot(1'b1, 1'b0, s);
  endtask : idle

  // whole frame; the line is released in turnaround and data of reads
  task automatic frame(input logic [1:0] st, op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hd;
    logic s;
    logic rdf;
    hd = {32'hFFFFFFFF, st, op, pa, ra};
    rdf = st[0] ? (op == 2'h2) : op[1];
    for (int i = 45; i >= 0; i--) slot(hd[i], 1'b1, s);
    slot(1'b1, !rdf, s);
    slot(1'b0, !rdf, s);
    for (int i = 15; i >= 0; i--) begin
      slot(wd[i], !rdf, s);
      rd[i] = s;
    end
    idle(2);
  endtask : frame
endmodule : mdio_station

// file: phy_mgmt_indirect_regs_bench.sv
`timescale 1ns/1ps
module phy_mgmt_indirect_regs_bench;
  logic clk = 1'b0, rst = 1'b1, strap = 1'b1, ierr = 1'b0, ridle = 1'b0, psm = 1'b0;
  logic mdc, sdrv, soe, mdo, mdo_oe, mdix, diag;
  logic [15:0] tv, rd, ptr;
  int fails = 0, cmp_count = 0, seed = 32'h481d868f;
  // pull-up holds the shared line high when nobody drives it
  wire logic mdio_w = mdo_oe ? mdo : (soe ? sdrv : 1'b1);

  always #2.5 clk = ~clk;

  phy_mgmt_indirect_regs dut_u (.i_sys_clk(clk), .i_rst(rst), .i_mdc(mdc), .i_mdio(mdio_w),
    .o_mdio(mdo), .o_mdio_oe(mdo_oe), .i_strap_auto_xover(strap), .i_idle_error(ierr),
    .i_rx_idle(ridle), .i_partner_sees_mdix(psm), .o_mdix_active(mdix),
    .o_diagnostics_clock_gate(diag), .o_idle_err_tally_view(tv));
  mdio_station stn_u (.o_mdc(mdc), .o_drv(sdrv), .o_drv_oe(soe), .i_wire(mdio_w));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    stn_u.frame(2'h1, 2'h1, 5'h00, ra, d, rd);
  endtask : wr

  task automatic rchk(input logic [4:0] ra, input logic [15:0] e);
    stn_u.frame(2'h1, 2'h2, 5'h00, ra, 16'h0000, rd);
    chk(rd, e);
  endtask : rchk

  task automatic c45(input logic [1:0] op, input logic [4:0] dv, input logic [15:0] d);
    stn_u.frame(2'h0, op, 5'h00, dv, d, rd);
  endtask : c45

  // mdc must tick during reset, so reset outlasts four mdc periods; the link
  // side leaves reset two mdc edges late, so three idle bits follow release
  task automatic do_reset(input logic s);
    @(negedge clk) rst = 1'b1;
    strap = s;
    stn_u.idle(4);
    @(negedge clk) rst = 1'b0;
    stn_u.idle(3);
  endtask : do_reset

  // idle errors spaced wide enough for the two-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk) ierr = 1'b1;
      repeat (2) @(negedge clk);
      ierr = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask : pulses

  // auto mode: manual bit is only a preference, flipped when the partner took it
  function automatic logic exp_mdix(input logic [15:0] c, input logic p);
    return c[10] ? c[9] ^ p : c[9];
  endfunction : exp_mdix

  task automatic end_sim;
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    logic [15:0] v, d;
    int n;
    do_reset(1'b1);
    rchk(5'h12, 16'h0402);
    rchk(5'h0F, 16'h0000);
    rchk(5'h10, 16'h0000);
    rchk(5'h1F, 16'h0000);
    // every auto/manual combination against both partner roles
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      v[10:9] = i[1:0];
      @(negedge clk) psm = i[2];
      wr(5'h12, v);
      chk(16'(diag), 16'(v[2]));
      chk(16'(mdix), 16'(exp_mdix(v, psm)));
      rchk(5'h12, v & 16'h0607);
    end
    repeat (4) begin
      ptr = $random(seed);
      d = $random(seed);
      wr(5'h10, ptr);
      wr(5'h11, d);
      rchk(5'h11, d);
      rchk(5'h10, ptr);
      c45(2'h0, 5'h1E, ptr);
      c45(2'h3, 5'h1E, 16'h0000);
      chk(rd, d);
      v = $random(seed);
      c45(2'h1, 5'h1E, v);
      rchk(5'h11, v);
      c45(2'h2, 5'h1E, 16'h0000);
      chk(rd, v);
      rchk(5'h10, ptr);
    end
    stn_u.frame(2'h1, 2'h1, 5'h01, 5'h10, ~ptr, rd);
    rchk(5'h10, ptr);
    c45(2'h3, 5'h01, 16'h0000);
    chk(rd, 16'h0000);
    @(negedge clk) ridle = 1'b1;
    n = 1 + ($random(seed) & 15);
    pulses(n);
    chk(tv, 16'(n));
    rchk(5'h0A, 16'(n));
    rchk(5'h0A, 16'h0000);
    @(negedge clk) ridle = 1'b0;
    pulses(3);
    rchk(5'h0A, 16'h0000);
    @(negedge clk) ridle = 1'b1;
    pulses(260);
    chk(tv, 16'h00FF);
    do_reset(1'b0);
    rchk(5'h12, 16'h0002);
    rchk(5'h10, 16'h0000);
    end_sim;
  end

  // hang guard
  initial begin
    #300us;
    fails++;
    end_sim;
  end
endmodule : phy_mgmt_indirect_regs_bench
